// ===== hdl/pro_pkg.sv
// Shared constants for the pixel readout and orientation block.
// Assumes a single 100 MHz master clock and nothing else.
package pro_pkg;
    // ****************************************************************
    // Array geometry
    // ****************************************************************
    localparam logic [10:0] PRO_COL_LAST = 11'h0_77F; // Column 1919
    localparam logic [10:0] PRO_ROW_LAST = 11'h0_437; // Row 1079
    localparam int PRO_PIX_W = 10;                    // Converted sample width
    localparam int PRO_WORD_W = 15;                   // Flags, colour and sample
    // ****************************************************************
    // Register map on the two-wire bus
    // ****************************************************************
    localparam logic [15:0] PRO_ORIENT_ADDR = 16'h0_101; // readout_orientation_ctrl
    localparam logic [7:0] PRO_ORIENT_RST = 8'h00;      // Normal scan
    localparam logic [7:0] PRO_ORIENT_MASK = 8'h03;     // Only [1:0] implemented
    localparam int PRO_ORIENT_MIRROR = 0;               // Column flip bit
    localparam int PRO_ORIENT_FLIP = 1;                 // Row flip bit
    localparam logic [6:0] PRO_DEV_ADDR = 7'h37;        // Write 0x6e, read 0x6f
    // ****************************************************************
    // Bayer colour codes {row parity, column parity}
    // ****************************************************************
    localparam logic [1:0] PRO_COL_GR = 2'h0;
    localparam logic [1:0] PRO_COL_R = 2'h1;
    localparam logic [1:0] PRO_COL_B = 2'h2;
    localparam logic [1:0] PRO_COL_GB = 2'h3;
    // ****************************************************************
    // State encodings
    // ****************************************************************
    typedef enum logic [2:0] {
        PRO_BUS_IDLE = 3'b000,
        PRO_BUS_RX = 3'b001,
        PRO_BUS_ACK = 3'b010,
        PRO_BUS_TX = 3'b011,
        PRO_BUS_TXACK = 3'b100,
        PRO_BUS_TXLD = 3'b101
    } pro_bus_st_t;
    typedef enum logic [0:0] {
        PRO_SCAN_IDLE = 1'b0,
        PRO_SCAN_RUN = 1'b1
    } pro_scan_st_t;
endpackage

// ===== hdl/pro_stream_if.sv
// Valid/ready carrier between the scanner and the output buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface pro_stream_if;
    logic valid;                           // Word offered
    logic ready;                           // Word accepted this cycle
    logic [pro_pkg::PRO_WORD_W-1:0] data;  // {sof, eol, eof, colour, sample}
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== hdl/pro_buf2.sv
// Two-entry buffer: an output register plus one skid register.
// Assumes a synchronous active-low reset on the shared clock.
`timescale 1ns/1ps
`default_nettype none
module pro_buf2
    import pro_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    pro_stream_if.snk in_s,
    output logic out_valid,
    input wire logic out_ready,
    output logic [PRO_WORD_W-1:0] out_data
);
    // ****************************************************************
    // Storage
    // ****************************************************************
    logic out_valid_q, out_valid_d;   // Output entry full
    logic skid_valid_q, skid_valid_d; // Skid entry full
    logic [PRO_WORD_W-1:0] out_data_q, out_data_d;
    logic [PRO_WORD_W-1:0] skid_data_q, skid_data_d;
    logic take;                       // Input handshake
    logic give;                       // Output handshake

    // Ready is a flop so the source never sees a combinational loop
    assign in_s.ready = ~skid_valid_q;
    assign out_valid = out_valid_q;
    assign out_data = out_data_q;

    // Next state of both entries
    always_comb begin
        take = in_s.valid & ~skid_valid_q;
        give = out_valid_q & out_ready;
        out_valid_d = out_valid_q;
        skid_valid_d = skid_valid_q;
        out_data_d = out_data_q;
        skid_data_d = skid_data_q;
        if (give | ~out_valid_q) begin
            // Output slot frees: refill from skid first, keeping order
            if (skid_valid_q) begin
                out_data_d = skid_data_q;
                out_valid_d = 1'b1;
                skid_valid_d = 1'b0;
            end else begin
                out_data_d = in_s.data;
                out_valid_d = take;
            end
        end else if (take) begin
            // Receiver stalled: park the word so nothing is lost
            skid_data_d = in_s.data;
            skid_valid_d = 1'b1;
        end
    end

    // Registers only
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            out_valid_q <= 1'b0;
            skid_valid_q <= 1'b0;
            out_data_q <= '0;
            skid_data_q <= '0;
        end else begin
            out_valid_q <= out_valid_d;
            skid_valid_q <= skid_valid_d;
            out_data_q <= out_data_d;
            skid_data_q <= skid_data_d;
        end
    end
endmodule
`default_nettype wire

// ===== hdl/pro_readout.sv
// Readout sequencer with orientation control and two-wire register slave.
// Assumes bus pins and the sample input are synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module pro_readout
    import pro_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic power_down_n,
    input wire logic sbcl_i,
    input wire logic sbda_i,
    output logic sbda_o,
    output logic sbda_oe_n,
    output logic [10:0] pix_row,
    output logic [10:0] pix_col,
    input wire logic [PRO_PIX_W-1:0] pix_sample,
    output logic px_valid,
    input wire logic px_ready,
    output logic [PRO_PIX_W-1:0] px_data,
    output logic [1:0] px_color,
    output logic px_sof,
    output logic px_eol,
    output logic px_eof
);
    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Bayer colour of a physical site: even rows green/red, odd blue/green
    function automatic logic [1:0] bayer_of(input logic [10:0] r, input logic [10:0] c);
        bayer_of = {r[0], c[0]};
    endfunction

    // Read data for a register address; unmapped reads return zero
    function automatic logic [7:0] reg_rd(input logic [15:0] a, input logic [7:0] v);
        reg_rd = (a == PRO_ORIENT_ADDR) ? (v & PRO_ORIENT_MASK) : 8'h00;
    endfunction

    // ****************************************************************
    // Two-wire slave
    // ****************************************************************
    pro_bus_st_t bst_q, bst_d;         // Bus state
    logic scl_q, sda_q;                // Previous pin samples
    logic [3:0] bit_q, bit_d;          // Bit counter within a byte
    logic [7:0] sh_q, sh_d;            // Shift register
    logic [1:0] idx_q, idx_d;          // Byte index, saturates at 3
    logic rw_q, rw_d;                  // Read transfer
    logic [15:0] addr_q, addr_d;       // Register pointer
    logic drv_q, drv_d;                // Pull data line low
    logic [7:0] orient_q, orient_d;    // readout_orientation_ctrl
    logic scl_rise, scl_fall, start_c, stop_c;

    // Edge and condition detection, then the byte sequencer
    always_comb begin
        scl_rise = sbcl_i & ~scl_q;
        scl_fall = ~sbcl_i & scl_q;
        start_c = sbcl_i & scl_q & sda_q & ~sbda_i;
        stop_c = sbcl_i & scl_q & ~sda_q & sbda_i;
        bst_d = bst_q;
        bit_d = bit_q;
        sh_d = sh_q;
        idx_d = idx_q;
        rw_d = rw_q;
        addr_d = addr_q;
        drv_d = drv_q;
        orient_d = orient_q;
        if (start_c) begin
            // Start or repeated start: expect a device address
            bst_d = PRO_BUS_RX;
            bit_d = 4'h0;
            idx_d = 2'h0;
            drv_d = 1'b0;
        end else if (stop_c) begin
            bst_d = PRO_BUS_IDLE;
            drv_d = 1'b0;
        end else begin
            case (bst_q)
                PRO_BUS_RX: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sbda_i};
                        bit_d = bit_q + 4'h1;
                    end else if (scl_fall && bit_q == 4'h8) begin
                        // Byte complete: decode by position
                        bit_d = 4'h0;
                        bst_d = PRO_BUS_ACK;
                        drv_d = 1'b1;
                        if (idx_q != 2'h3) begin
                            idx_d = idx_q + 2'h1;
                        end
                        case (idx_q)
                            2'h0: begin
                                rw_d = sh_q[0];
                                if (sh_q[7:1] != PRO_DEV_ADDR) begin
                                    bst_d = PRO_BUS_IDLE;
                                    drv_d = 1'b0;
                                end
                            end
                            2'h1: addr_d = {sh_q, addr_q[7:0]};
                            2'h2: addr_d = {addr_q[15:8], sh_q};
                            default: begin
                                // Data byte: write, then advance pointer
                                if (addr_q == PRO_ORIENT_ADDR) begin
                                    orient_d = sh_q & PRO_ORIENT_MASK;
                                end
                                addr_d = addr_q + 16'h0001;
                            end
                        endcase
                    end
                end
                PRO_BUS_ACK: begin
                    if (scl_fall) begin
                        // Acknowledge bit ends; reads start after address byte
                        if (rw_q && idx_q == 2'h1) begin
                            sh_d = reg_rd(addr_q, orient_q);
                            drv_d = ~sh_d[7];
                            bst_d = PRO_BUS_TX;
                        end else begin
                            drv_d = 1'b0;
                            bst_d = PRO_BUS_RX;
                        end
                    end
                end
                PRO_BUS_TX: begin
                    if (scl_fall) begin
                        if (bit_q == 4'h7) begin
                            // Release for the master's acknowledge
                            drv_d = 1'b0;
                            bit_d = 4'h0;
                            addr_d = addr_q + 16'h0001;
                            bst_d = PRO_BUS_TXACK;
                        end else begin
                            sh_d = {sh_q[6:0], 1'b0};
                            drv_d = ~sh_q[6];
                            bit_d = bit_q + 4'h1;
                        end
                    end
                end
                PRO_BUS_TXACK: begin
                    // No acknowledge from master ends the read
                    if (scl_rise) begin
                        bst_d = sbda_i ? PRO_BUS_IDLE : PRO_BUS_TXLD;
                    end
                end
                PRO_BUS_TXLD: begin
                    if (scl_fall) begin
                        sh_d = reg_rd(addr_q, orient_q);
                        drv_d = ~sh_d[7];
                        bst_d = PRO_BUS_TX;
                    end
                end
                default: begin
                    drv_d = 1'b0;
                end
            endcase
        end
    end

    // Bus registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bst_q <= PRO_BUS_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            idx_q <= 2'h0;
            rw_q <= 1'b0;
            addr_q <= 16'h0000;
            drv_q <= 1'b0;
            sbda_oe_n <= 1'b1;
            orient_q <= PRO_ORIENT_RST;
        end else begin
            bst_q <= bst_d;
            scl_q <= sbcl_i;
            sda_q <= sbda_i;
            bit_q <= bit_d;
            sh_q <= sh_d;
            idx_q <= idx_d;
            rw_q <= rw_d;
            addr_q <= addr_d;
            drv_q <= drv_d;
            sbda_oe_n <= ~drv_d;
            orient_q <= orient_d;
        end
    end

    // Open-drain data line: drive low only; enable is its own flop
    assign sbda_o = 1'b0;

    // ****************************************************************
    // Array scanner
    // ****************************************************************
    pro_scan_st_t sst_q, sst_d;        // Scanner state
    logic [10:0] row_q, row_d;         // Physical row being read
    logic [10:0] col_q, col_d;         // Physical column being read
    logic [1:0] act_q, act_d;          // Orientation of current frame
    logic first_q, first_d;            // Next word opens the frame
    logic [10:0] col_end, row_end;     // Last site in scan order
    logic push;                        // Word handed to the buffer
    pro_stream_if scan_s ();

    // Step through the array in the direction the frame latched
    always_comb begin
        col_end = act_q[PRO_ORIENT_MIRROR] ? 11'h000 : PRO_COL_LAST;
        row_end = act_q[PRO_ORIENT_FLIP] ? 11'h000 : PRO_ROW_LAST;
        push = (sst_q == PRO_SCAN_RUN) & scan_s.ready;
        scan_s.valid = (sst_q == PRO_SCAN_RUN);
        scan_s.data = {first_q, col_q == col_end,
                       (col_q == col_end) & (row_q == row_end),
                       bayer_of(row_q, col_q), pix_sample};
        sst_d = sst_q;
        row_d = row_q;
        col_d = col_q;
        act_d = act_q;
        first_d = first_q;
        case (sst_q)
            PRO_SCAN_IDLE: begin
                if (power_down_n) begin
                    // Latch orientation only here, between frames
                    act_d = orient_q[1:0];
                    col_d = orient_q[PRO_ORIENT_MIRROR] ? PRO_COL_LAST : 11'h000;
                    row_d = orient_q[PRO_ORIENT_FLIP] ? PRO_ROW_LAST : 11'h000;
                    first_d = 1'b1;
                    sst_d = PRO_SCAN_RUN;
                end
            end
            PRO_SCAN_RUN: begin
                if (!power_down_n) begin
                    // Standby abandons the frame
                    sst_d = PRO_SCAN_IDLE;
                end else if (push) begin
                    first_d = 1'b0;
                    if (col_q != col_end) begin
                        col_d = act_q[PRO_ORIENT_MIRROR] ? col_q - 11'h001 : col_q + 11'h001;
                    end else if (row_q != row_end) begin
                        // Next row, progressive order
                        col_d = act_q[PRO_ORIENT_MIRROR] ? PRO_COL_LAST : 11'h000;
                        row_d = act_q[PRO_ORIENT_FLIP] ? row_q - 11'h001 : row_q + 11'h001;
                    end else begin
                        sst_d = PRO_SCAN_IDLE;
                    end
                end
            end
            default: begin
                sst_d = PRO_SCAN_IDLE;
            end
        endcase
    end

    // Scanner registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sst_q <= PRO_SCAN_IDLE;
            row_q <= 11'h000;
            col_q <= 11'h000;
            act_q <= 2'h0;
            first_q <= 1'b0;
        end else begin
            sst_q <= sst_d;
            row_q <= row_d;
            col_q <= col_d;
            act_q <= act_d;
            first_q <= first_d;
        end
    end

    assign pix_row = row_q;
    assign pix_col = col_q;

    // ****************************************************************
    // Output buffer toward the link
    // ****************************************************************
    logic [PRO_WORD_W-1:0] out_word;

    pro_buf2 u_buf (
        .mclk(mclk),
        .rst_n(rst_n),
        .in_s(scan_s),
        .out_valid(px_valid),
        .out_ready(px_ready),
        .out_data(out_word)
    );

    assign px_sof = out_word[14];
    assign px_eol = out_word[13];
    assign px_eof = out_word[12];
    assign px_color = out_word[11:10];
    assign px_data = out_word[9:0];
endmodule
`default_nettype wire

// ===== dv/pro_readout_props.sv
// Port checker for the readout block.
// Assumes it is bound onto pro_readout and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pro_readout_props
    import pro_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic power_down_n,
    input wire logic sbcl_i,
    input wire logic sbda_i,
    input wire logic sbda_o,
    input wire logic sbda_oe_n,
    input wire logic [10:0] pix_row,
    input wire logic [10:0] pix_col,
    input wire logic [PRO_PIX_W-1:0] pix_sample,
    input wire logic px_valid,
    input wire logic px_ready,
    input wire logic [PRO_PIX_W-1:0] px_data,
    input wire logic [1:0] px_color,
    input wire logic px_sof,
    input wire logic px_eol,
    input wire logic px_eof
);
    // ****************************************************************
    // Last accepted word; only the seen flag is cleared by reset or standby
    // ****************************************************************
    logic [1:0] last_q; // Colour of last word
    logic eol_q; // Last word closed a row
    logic have_q; // A word of this frame was seen
    always_ff @(posedge mclk) begin
        if (!rst_n || !power_down_n) begin
            have_q <= 1'b0;
        end else if (px_valid && px_ready) begin
            have_q <= 1'b1;
        end
        if (px_valid && px_ready) begin
            last_q <= px_color;
            eol_q <= px_eol;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_word_hold: assert property (px_valid && !px_ready ##1 power_down_n |->
        px_valid && $stable({px_data, px_color, px_sof, px_eol, px_eof}))
        else $error("stalled word changed");
    a_color_walk: assert property (px_valid && have_q && !px_sof |->
        px_color == {last_q[1] ^ eol_q, ~last_q[0]}) else $error("colour phase wrong");
    a_eof_ends_row: assert property (px_valid && px_eof |-> px_eol)
        else $error("frame end without row end");
    a_sof_alone: assert property (px_valid && px_sof |-> !px_eol && !px_eof)
        else $error("frame start marked as end");
    a_col_step: assert property ($changed(pix_col) |-> pix_col == $past(pix_col) + 11'd1 ||
        pix_col == $past(pix_col) - 11'd1 || pix_col == 11'd0 || pix_col == PRO_COL_LAST)
        else $error("column jump");
    a_addr_range: assert property (pix_row <= PRO_ROW_LAST && pix_col <= PRO_COL_LAST)
        else $error("address outside array");
    a_ack_drive: assert property ($rose(sbda_oe_n) |-> !sbcl_i && !$past(sbcl_i) && !sbda_o)
        else $error("bus release outside low clock");
    a_ack_timing: assert property ($fell(sbda_oe_n) |-> !sbcl_i && !$past(sbcl_i))
        else $error("bus drive began outside low clock");
    a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !px_valid && sbda_oe_n)
        else $error("outputs active after reset");
    c_sof: cover property (px_valid && px_ready && px_sof);
    c_eol: cover property (px_valid && px_ready && px_eol);
    c_ack: cover property (!sbda_oe_n);
endmodule
bind pro_readout pro_readout_props pro_readout_props_i (.mclk(mclk), .rst_n(rst_n),
    .power_down_n(power_down_n), .sbcl_i(sbcl_i), .sbda_i(sbda_i), .sbda_o(sbda_o),
    .sbda_oe_n(sbda_oe_n), .pix_row(pix_row), .pix_col(pix_col), .pix_sample(pix_sample),
    .px_valid(px_valid), .px_ready(px_ready), .px_data(px_data), .px_color(px_color),
    .px_sof(px_sof), .px_eol(px_eol), .px_eof(px_eof));
`default_nettype wire

// ===== dv/pro_host_model.sv
// Far-side model: pixel array, stream receiver, two-wire bus master.
// Assumes one mclk; master drive, bus clock and receiver ready change at its falling edge.
`timescale 1ns/1ps
`default_nettype none
module pro_host_model
    import pro_pkg::*;
(
    input wire logic mclk,
    output logic sbcl_i,
    output logic sbda_i,
    input wire logic sbda_o,
    input wire logic sbda_oe_n,
    input wire logic [10:0] pix_row,
    input wire logic [10:0] pix_col,
    output logic [PRO_PIX_W-1:0] pix_sample,
    output logic px_ready
);
    logic sda_m = 1'b1; // Master drive, high means released
    logic stall_en = 1'b0; // Receiver throttles when set
    logic [1:0] cnt_q = 2'h0; // Stall pattern
    initial sbcl_i = 1'b1;
    initial px_ready = 1'b0;
    // Pulled-up wire resolved from both drivers
    assign sbda_i = sda_m & (sbda_oe_n | sbda_o);
    // Site sample encodes its own address
    always_comb pix_sample = {pix_row[4:0], pix_col[4:0]};
    // Receiver accepts half the time while stalling
    always @(negedge mclk) begin
        cnt_q <= cnt_q + 2'h1;
        px_ready <= !stall_en || cnt_q[1];
    end
    task automatic half();
        repeat (4) @(negedge mclk);
    endtask
    // One bit: data set while clock low, line sampled while high
    task automatic bit_io(input logic b, output logic s);
        @(negedge mclk);
        sda_m = b;
        half();
        sbcl_i = 1'b1;
        half();
        s = sbda_i;
        sbcl_i = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] w, input logic mack, output logic [7:0] r,
        output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
        bit_io(mack, ack);
        ack = !ack;
    endtask
    task automatic start();
        @(negedge mclk);
        sda_m = 1'b1;
        half();
        sbcl_i = 1'b1;
        half();
        sda_m = 1'b0;
        half();
        sbcl_i = 1'b0;
    endtask
    task automatic stop();
        @(negedge mclk);
        sda_m = 1'b0;
        half();
        sbcl_i = 1'b1;
        half();
        sda_m = 1'b1;
        half();
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d, input logic [7:0] dev,
        output logic ok);
        logic [7:0] r;
        logic k0, k1, k2, k3;
        start();
        xfer(dev, 1'b1, r, k0);
        xfer(a[15:8], 1'b1, r, k1);
        xfer(a[7:0], 1'b1, r, k2);
        xfer(d, 1'b1, r, k3);
        stop();
        ok = k0 & k1 & k2 & k3;
    endtask
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic k0, k1, k2, k3, kn;
        start();
        xfer({PRO_DEV_ADDR, 1'b0}, 1'b1, r, k0);
        xfer(a[15:8], 1'b1, r, k1);
        xfer(a[7:0], 1'b1, r, k2);
        start();
        xfer({PRO_DEV_ADDR, 1'b1}, 1'b1, r, k3);
        xfer(8'hFF, 1'b1, d, kn);
        stop();
        ok = k0 & k1 & k2 & k3;
    endtask
endmodule
`default_nettype wire

// ===== dv/tb_pro_readout.sv
// Self-checking bench for the readout block.
// Assumes the host model drives the bus and the receive side.
`timescale 1ns/1ps
`default_nettype none
module tb_pro_readout
    import pro_pkg::*;
();
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic power_down_n = 1'b1;
    logic sbcl_i, sbda_i, sbda_o, sbda_oe_n, px_valid, px_ready, px_sof, px_eol, px_eof;
    logic [10:0] pix_row, pix_col;
    logic [9:0] pix_sample, px_data;
    logic [1:0] px_color;
    logic [1:0] first_col [4] = '{PRO_COL_GR, PRO_COL_R, PRO_COL_B, PRO_COL_GB};
    logic [PRO_WORD_W-1:0] words[$]; // Accepted words in order
    int num_errors = 0;
    int check_count = 0;
    always #5 mclk = ~mclk;
    pro_readout pro_readout_i (.mclk(mclk), .rst_n(rst_n), .power_down_n(power_down_n),
        .sbcl_i(sbcl_i), .sbda_i(sbda_i), .sbda_o(sbda_o), .sbda_oe_n(sbda_oe_n),
        .pix_row(pix_row), .pix_col(pix_col), .pix_sample(pix_sample), .px_valid(px_valid),
        .px_ready(px_ready), .px_data(px_data), .px_color(px_color), .px_sof(px_sof),
        .px_eol(px_eol), .px_eof(px_eof));
    pro_host_model pro_host_model_i (.mclk(mclk), .sbcl_i(sbcl_i), .sbda_i(sbda_i),
        .sbda_o(sbda_o), .sbda_oe_n(sbda_oe_n), .pix_row(pix_row), .pix_col(pix_col),
        .pix_sample(pix_sample), .px_ready(px_ready));
    always @(posedge mclk) begin
        if (px_valid === 1'b1 && px_ready === 1'b1) begin
            words.push_back({px_sof, px_eol, px_eof, px_color, px_data});
        end
    end
    function automatic logic [9:0] smp(input logic [10:0] r, input logic [10:0] c);
        return {r[4:0], c[4:0]};
    endfunction
    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Next accepted word, bounded wait
    task automatic pop(output logic [PRO_WORD_W-1:0] w);
        for (int n = 0; n < 5000 && words.size() == 0; n++) @(negedge mclk);
        if (words.size() == 0) begin
            chk("word arrival", 16'h0001, 16'h0000);
            stop_test();
        end else begin
            w = words.pop_front();
        end
    endtask
    task automatic test_reset();
        logic [PRO_WORD_W-1:0] w;
        logic [7:0] d;
        logic ok;
        pop(w);
        chk("reset first word", {1'b0, 3'b100, PRO_COL_GR, smp(11'h0, 11'h0)}, w);
        pro_host_model_i.wr_reg(PRO_ORIENT_ADDR, 8'h01, 8'h50, ok);
        chk("foreign address ack", 16'h0000, ok);
        pro_host_model_i.rd_reg(PRO_ORIENT_ADDR, d, ok);
        chk("reset register", {ok, PRO_ORIENT_RST}, {1'b1, d});
        pro_host_model_i.rd_reg(16'h0_102, d, ok);
        chk("unmapped read", 16'h0100, {ok, d});
    endtask
    task automatic test_orient(input logic [1:0] o, input logic [7:0] v, input logic [1:0] old,
        input logic stall);
        logic [PRO_WORD_W-1:0] w, p;
        logic [7:0] d;
        logic ok;
        logic [10:0] r0, c;
        pro_host_model_i.wr_reg(PRO_ORIENT_ADDR, v, {PRO_DEV_ADDR, 1'b0}, ok);
        chk("orientation write ack", 16'h0001, ok);
        words.delete();
        pop(p);
        pop(w);
        if (p[13]) begin
            p = w;
            pop(w);
        end
        chk("running column step", old[0] ? 5'h1f : 5'h01, 5'(w[4:0] - p[4:0]));
        pro_host_model_i.rd_reg(PRO_ORIENT_ADDR, d, ok);
        chk("orientation readback", {1'b1, 6'h00, o}, {ok, d});
        power_down_n = 1'b0;
        repeat (12) @(negedge mclk);
        chk("standby output", 16'h0000, px_valid);
        words.delete();
        pro_host_model_i.stall_en = stall;
        power_down_n = 1'b1;
        r0 = o[1] ? PRO_ROW_LAST : 11'h000;
        c = o[0] ? PRO_COL_LAST : 11'h000;
        pop(w);
        chk("first word", {1'b0, 3'b100, first_col[o], smp(r0, c)}, w);
        for (int i = 1; i < 1920; i++) begin
            c = o[0] ? c - 11'd1 : c + 11'd1;
            pop(w);
            chk("row word", {2'b00, i == 1919, 1'b0, r0[0], c[0], smp(r0, c)}, w);
        end
        r0 = o[1] ? r0 - 11'd1 : r0 + 11'd1;
        c = o[0] ? PRO_COL_LAST : 11'h000;
        pop(w);
        chk("second row", {4'b0000, r0[0], c[0], smp(r0, c)}, w);
    endtask
    // Mid-run reset restores normal orientation and a fresh frame
    task automatic test_rerun();
        logic [PRO_WORD_W-1:0] w;
        logic [7:0] d;
        logic ok;
        pro_host_model_i.wr_reg(PRO_ORIENT_ADDR, 8'h03, {PRO_DEV_ADDR, 1'b0}, ok);
        chk("pre-reset write ack", 16'h0001, ok);
        rst_n = 1'b0;
        repeat (20) @(negedge mclk);
        words.delete();
        rst_n = 1'b1;
        pop(w);
        chk("rerun first word", {1'b0, 3'b100, PRO_COL_GR, smp(11'h0, 11'h0)}, w);
        pro_host_model_i.rd_reg(PRO_ORIENT_ADDR, d, ok);
        chk("rerun register", {1'b1, PRO_ORIENT_RST}, {ok, d});
    endtask
    initial begin
        repeat (60000) @(posedge mclk);
        chk("watchdog", 16'h0001, 16'h0000);
        stop_test();
    end
    initial begin
        repeat (20) @(negedge mclk);
        rst_n = 1'b1;
        test_reset();
        test_orient(2'b01, 8'h01, 2'b00, 1'b1);
        test_orient(2'b10, 8'h02, 2'b01, 1'b0);
        test_orient(2'b11, 8'hFF, 2'b10, 1'b1);
        test_orient(2'b00, 8'h00, 2'b11, 1'b0);
        test_rerun();
        stop_test();
    end
endmodule
`default_nettype wire
